// ### hw/port_pkg.sv
// port_pkg: shared constants and carrier types for the seven-port io data path
// assumes a host register decoder outside that presents port index and strobes
package port_pkg;
	localparam int num_ports = 7;
	localparam int port_w = 8;
	localparam int port_d_w = 4;
	// port indices
	localparam logic [2:0] port_a = 3'h0;
	localparam logic [2:0] port_b = 3'h1;
	localparam logic [2:0] port_c = 3'h2;
	localparam logic [2:0] port_d = 3'h3;
	localparam logic [2:0] port_e = 3'h4;
	localparam logic [2:0] port_f = 3'h5;
	localparam logic [2:0] port_g = 3'h6;
	// register selects within a port's register block
	localparam logic [2:0] reg_pin_input_level = 3'h0;
	localparam logic [2:0] reg_output_latch = 3'h1;
	localparam logic [2:0] reg_direction = 3'h2;
	localparam logic [2:0] reg_drive_select = 3'h3;
	localparam logic [2:0] reg_control = 3'h4;
	// reset values: every configuration and latch register powers up at zero
	localparam logic [7:0] reg_reset = 8'h00;
	localparam logic [3:0] port_d_mask = 4'hf;
	// port d pin roles
	localparam int port_d_pin_zero = 0;
	localparam int port_d_pin_one = 1;
	localparam int port_d_pin_two = 2;
	localparam int port_d_pin_three = 3;
	// port e pin roles
	localparam int port_e_pin_seven = 7;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [2:0] port;
		logic [2:0] sel;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] open_drain;
		logic [7:0] fast_slew;
	} pin_drive_t;
endpackage

// ### hw/pin_driver.sv
// pin_driver: per-pin output selection for one port
// assumes the data, enable and drive mode inputs are already resolved by the port
`timescale 1ns/1ns
`default_nettype none
module pin_driver #(
	parameter int width = 8
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [width-1:0] data,
	input wire logic [width-1:0] enable,
	input wire logic [width-1:0] open_drain,
	output logic [width-1:0] pin_out,
	output logic [width-1:0] pin_oe
);
	// ==========================================================
	// registered drivers
	// open drain pins only ever pull low; a one releases the pin to the pull-up
	genvar i;
	generate
		for (i = 0; i < width; i++) begin : g_pin
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					pin_out[i] <= 1'b0;
					pin_oe[i] <= 1'b0;
				end else begin
					pin_out[i] <= open_drain[i] ? 1'b0 : data[i];
					pin_oe[i] <= enable[i] & ~(open_drain[i] & data[i]);
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ### hw/addr_latch.sv
// addr_latch: captures host address on the address strobe
// assumes the strobe is synchronous to clk_sys and high while the address is valid
`timescale 1ns/1ns
`default_nettype none
module addr_latch #(
	parameter int width = 16
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic strobe,
	input wire logic [width-1:0] addr_in,
	output logic [width-1:0] addr_q
);
	import port_pkg::*;
	// ==========================================================
	// loads the address on each clock edge while the strobe is high, holds after it falls
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			addr_q <= '0;
		end else if (strobe) begin
			addr_q <= addr_in;
		end
	end
endmodule
`default_nettype wire

// ### hw/io_port_path.sv
// io_port_path: data path, registers and function selection for ports a to g
// assumes host register accesses arrive as one-cycle strobes synchronous to clk_sys;
// logic array terms and static configuration straps come from neighbouring blocks
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - input level register reads the live pin level in host io input mode.
// - output latch drives pin when direction bit or array enable is one; where array enable is one, the array output drives the pin instead.
// - reading the output latch returns the written value, not the pin.
// - ports a and b: array outputs, array inputs, strobe-latched high address; here the array inputs come from port d pins only.
// - port c has fast slew bits; ports a and b have open drain.
// - port d has four pins; only low four register bits are meaningful.
// - port d pin zero is address strobe, pin one the logic clock input.
// - chip select high disables flash, sram and io register space.
// - port d pin three is high byte write enable or byte enable.
// - port e pins given to the test port leave all other functions.
// - battery indicator pin asserts while supply is below battery.
// - port e can output the latched low address byte.
// - port f: io, array input, address in/out, slew, reset pattern; here port f has no array input and no address in, only address out.
// - port f carries data bits 7 to 0 as non-multiplexed data port.
// - port g carries data bits 15 to 8, open drain, address out.
// - direction one is output, zero input; everything resets to input.
// - control zero selects host io, one selects address out, on e f g.
// - reset pattern mode drives pattern on f and g during reset, no cycle.
module io_port_path #(
	parameter int num_ports = 7,
	parameter int addr_w = 16
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire port_pkg::reg_req_t req,
	output logic [7:0] rdata,
	input wire logic [num_ports*8-1:0] pin_in,
	output logic [num_ports*8-1:0] pin_out,
	output logic [num_ports*8-1:0] pin_oe,
	output logic [num_ports*8-1:0] pin_fast_slew,
	input wire logic [15:0] array_out,
	input wire logic [15:0] array_oe,
	input wire logic [addr_w-1:0] host_addr,
	input wire logic [15:0] host_wdata,
	output logic [15:0] host_rdata,
	input wire logic host_read_cycle,
	input wire logic host_bus_cycle,
	input wire logic host_reset_active,
	input wire logic data_port_mode,
	input wire logic reset_pattern_mode,
	input wire logic [15:0] reset_pattern,
	input wire logic [3:0] port_d_special,
	input wire logic port_d_three_is_byte_enable,
	input wire logic [7:0] test_port_pins,
	input wire logic battery_indicator_en,
	input wire logic supply_below_battery,
	output logic [7:0] array_input_level,
	output logic [15:0] high_addr_latched,
	output logic address_strobe,
	output logic logic_clock_input,
	output logic memory_select_off,
	output logic high_byte_write_enable_n,
	output logic data_byte_enable_input
);
	import port_pkg::*;

	initial begin
		if (num_ports != 7 || addr_w < 16) begin
			$error("io_port_path: needs seven ports and at least 16 address bits");
		end
	end

	// ==========================================================
	// register storage
	logic [7:0] out_latch [num_ports];
	logic [7:0] direction [num_ports];
	logic [7:0] drive_sel [num_ports];
	logic [7:0] control [num_ports];
	logic [7:0] reg_mask [num_ports];

	genvar p;
	generate
		for (p = 0; p < num_ports; p++) begin : g_regs
			// port d has four pins; upper bits never store
			assign reg_mask[p] = (p == port_d) ? {4'h0, port_d_mask} : 8'hff;
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					out_latch[p] <= reg_reset;
					direction[p] <= reg_reset;
					drive_sel[p] <= reg_reset;
					control[p] <= reg_reset;
				end else if (req.wr && req.port == 3'(p)) begin
					case (req.sel)
						reg_output_latch: out_latch[p] <= req.wdata & reg_mask[p];
						reg_direction: direction[p] <= req.wdata & reg_mask[p];
						reg_drive_select: drive_sel[p] <= req.wdata & reg_mask[p];
						reg_control: begin
							// only e, f and g carry a control register
							if (p >= port_e) begin
								control[p] <= req.wdata;
							end
						end
						default: ;
					endcase
				end
			end
		end
	endgenerate

	// ==========================================================
	// address capture on the strobe from port d pin zero
	logic strobe_pin;
	logic [15:0] addr_q;
	assign strobe_pin = port_d_special[port_d_pin_zero] & pin_in[port_d*8 + port_d_pin_zero];

	addr_latch #(.width(16)) u_addr (
		.clk_sys(clk_sys),
		.rst(rst),
		.strobe(strobe_pin),
		.addr_in(host_addr[15:0]),
		.addr_q(addr_q)
	);

	// ==========================================================
	// per-port output resolution
	logic [7:0] next_data [num_ports];
	logic [7:0] next_en [num_ports];
	logic [7:0] open_drain [num_ports];
	logic [num_ports*8-1:0] flat_data;
	logic [num_ports*8-1:0] flat_en;
	logic [num_ports*8-1:0] flat_od;
	logic data_drive;
	logic pattern_drive;

	// data port drives only on host reads; pattern only in reset with the bus idle
	assign data_drive = data_port_mode & host_read_cycle & ~host_reset_active;
	assign pattern_drive = reset_pattern_mode & host_reset_active & ~host_bus_cycle;

	always_comb begin
		for (int i = 0; i < num_ports; i++) begin
			next_data[i] = out_latch[i];
			next_en[i] = direction[i];
			open_drain[i] = 8'h00;
		end
		// ports a and b: array outputs override with their own enables
		for (int i = 0; i < 8; i++) begin
			if (array_oe[i]) begin
				next_data[port_a][i] = array_out[i];
			end
			if (array_oe[8+i]) begin
				next_data[port_b][i] = array_out[8+i];
			end
		end
		next_en[port_a] = direction[port_a] | array_oe[7:0];
		next_en[port_b] = direction[port_b] | array_oe[15:8];
		open_drain[port_a] = drive_sel[port_a];
		open_drain[port_b] = drive_sel[port_b];
		open_drain[port_d] = drive_sel[port_d] & {4'h0, port_d_mask};
		open_drain[port_e] = drive_sel[port_e];
		open_drain[port_g] = drive_sel[port_g];
		// port d special inputs never drive
		next_en[port_d] = direction[port_d] & ~{4'h0, port_d_special} & {4'h0, port_d_mask};
		// address out on e, f, g where control bit is one
		for (int i = 0; i < 8; i++) begin
			if (control[port_e][i]) begin
				next_data[port_e][i] = addr_q[i];
				next_en[port_e][i] = 1'b1;
			end
			if (control[port_f][i]) begin
				next_data[port_f][i] = addr_q[i];
				next_en[port_f][i] = 1'b1;
			end
			if (control[port_g][i]) begin
				next_data[port_g][i] = addr_q[8+i];
				next_en[port_g][i] = 1'b1;
			end
		end
		// battery indicator on port e pin seven
		if (battery_indicator_en) begin
			next_data[port_e][port_e_pin_seven] = supply_below_battery;
			next_en[port_e][port_e_pin_seven] = 1'b1;
			open_drain[port_e][port_e_pin_seven] = 1'b0;
		end
		// data port and reset pattern replace general io on f and g
		if (data_port_mode || reset_pattern_mode) begin
			next_data[port_f] = pattern_drive ? reset_pattern[7:0] : host_wdata[7:0];
			next_data[port_g] = pattern_drive ? reset_pattern[15:8] : host_wdata[15:8];
			next_en[port_f] = {8{data_drive | pattern_drive}};
			next_en[port_g] = {8{data_drive | pattern_drive}};
			open_drain[port_g] = 8'h00;
		end
		// test port pins belong to the programming port only
		next_en[port_e] = next_en[port_e] & ~test_port_pins;
	end

	generate
		for (p = 0; p < num_ports; p++) begin : g_flat
			assign flat_data[p*8 +: 8] = next_data[p];
			assign flat_en[p*8 +: 8] = next_en[p];
			assign flat_od[p*8 +: 8] = open_drain[p];
		end
	endgenerate

	pin_driver #(.width(num_ports*8)) u_drv (
		.clk_sys(clk_sys),
		.rst(rst),
		.data(flat_data),
		.enable(flat_en),
		.open_drain(flat_od),
		.pin_out(pin_out),
		.pin_oe(pin_oe)
	);

	// ==========================================================
	// slew selection: only c and f carry a slew bit
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_fast_slew <= '0;
		end else begin
			pin_fast_slew <= '0;
			pin_fast_slew[port_c*8 +: 8] <= drive_sel[port_c];
			pin_fast_slew[port_f*8 +: 8] <= drive_sel[port_f];
		end
	end

	// ==========================================================
	// register read port; test port pins read zero from the input register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata <= reg_reset;
		end else if (req.rd) begin
			case (req.sel)
				reg_pin_input_level: begin
					rdata <= pin_in[req.port*8 +: 8] & reg_mask[req.port];
					if (req.port == port_e) begin
						rdata <= pin_in[port_e*8 +: 8] & ~test_port_pins;
					end
				end
				reg_output_latch: rdata <= out_latch[req.port];
				reg_direction: rdata <= direction[req.port];
				reg_drive_select: rdata <= drive_sel[req.port];
				reg_control: rdata <= (req.port >= port_e) ? control[req.port] : reg_reset;
				default: rdata <= reg_reset;
			endcase
		end
	end

	// ==========================================================
	// inputs to the logic arrays and the host side
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			array_input_level <= '0;
			high_addr_latched <= '0;
			host_rdata <= '0;
			address_strobe <= 1'b0;
			logic_clock_input <= 1'b0;
			memory_select_off <= 1'b1;
			high_byte_write_enable_n <= 1'b1;
			data_byte_enable_input <= 1'b0;
		end else begin
			// port d pins feed the arrays directly
			array_input_level <= {4'h0, pin_in[port_d*8 +: 4]};
			// high address inputs on a and b, held by the strobe
			if (strobe_pin) begin
				high_addr_latched <= pin_in[port_a*8 +: 16];
			end
			host_rdata <= {pin_in[port_g*8 +: 8], pin_in[port_f*8 +: 8]};
			address_strobe <= strobe_pin;
			logic_clock_input <= port_d_special[port_d_pin_one] &
				pin_in[port_d*8 + port_d_pin_one];
			// a high chip select deselects the memories and io space
			memory_select_off <= port_d_special[port_d_pin_two] &
				pin_in[port_d*8 + port_d_pin_two];
			high_byte_write_enable_n <= ~(port_d_special[port_d_pin_three] &
				~port_d_three_is_byte_enable & ~pin_in[port_d*8 + port_d_pin_three]);
			data_byte_enable_input <= port_d_special[port_d_pin_three] &
				port_d_three_is_byte_enable & pin_in[port_d*8 + port_d_pin_three];
		end
	end
endmodule
`default_nettype wire

// ### verif/io_port_path_properties.sv
// io_port_path_properties: port-level checks for the io port data path
// assumes bind onto io_port_path, one clock, synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module io_port_path_properties #(
	parameter int num_ports = 7
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire port_pkg::reg_req_t req,
	input wire logic [7:0] rdata,
	input wire logic [num_ports*8-1:0] pin_in,
	input wire logic [num_ports*8-1:0] pin_out,
	input wire logic [num_ports*8-1:0] pin_oe,
	input wire logic [num_ports*8-1:0] pin_fast_slew,
	input wire logic [15:0] host_wdata,
	input wire logic host_read_cycle,
	input wire logic data_port_mode,
	input wire logic [3:0] port_d_special,
	input wire logic [7:0] test_port_pins,
	input wire logic battery_indicator_en,
	input wire logic supply_below_battery,
	input wire logic memory_select_off
);
	import port_pkg::*;
	logic [7:0] latch_c;
	logic [7:0] dir_c;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// ==========
	// shadow of port c registers, kept from the write strobes alone
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			latch_c <= reg_reset;
			dir_c <= reg_reset;
		end else if (req.wr && req.port == port_c) begin
			if (req.sel == reg_output_latch) latch_c <= req.wdata;
			if (req.sel == reg_direction) dir_c <= req.wdata;
		end
	end
	sequence rd_of(logic [2:0] p, logic [2:0] s);
		req.rd && req.port == p && req.sel == s;
	endsequence
	sequence ctl_rd;
		req.rd && req.port < port_e && req.sel == reg_control;
	endsequence
	// ==========
	// past(rst) guard: a mid-run reset leaves stale shadow values in past
	oe_follows_dir_a: assert property (!$past(rst) |-> pin_oe[23:16] == $past(dir_c))
		else $error("port c enable differs from direction");
	out_follows_latch_a: assert property (!$past(rst) |->
		(pin_out[23:16] & pin_oe[23:16]) == ($past(latch_c) & pin_oe[23:16]))
		else $error("port c drives a value other than the latch");
	latch_readback_a: assert property (rd_of(port_c, reg_output_latch) |=> rdata == latch_c)
		else $error("latch read returns wrong value");
	input_level_a: assert property (rd_of(port_c, reg_pin_input_level) |=>
		rdata == $past(pin_in[23:16]))
		else $error("input level read differs from pins");
	port_d_mask_a: assert property (rd_of(port_d, reg_output_latch) |=> rdata[7:4] == 4'h0)
		else $error("port d upper bits not zero");
	no_control_a: assert property (ctl_rd |=> rdata == 8'h00)
		else $error("control read nonzero on a port without control");
	slew_only_cf_a: assert property ({pin_fast_slew[55:48], pin_fast_slew[39:24],
		pin_fast_slew[15:0]} == 40'h0)
		else $error("fast slew on a port without slew control");
	chip_select_a: assert property (port_d_special[2] && pin_in[26] |=> memory_select_off)
		else $error("chip select high does not deselect");
	test_port_a: assert property (!$past(rst) |->
		(pin_oe[39:32] & $past(test_port_pins)) == 8'h00)
		else $error("test port pin driven");
	battery_a: assert property (battery_indicator_en && supply_below_battery |=> pin_out[39])
		else $error("battery indicator not raised");
	data_port_a: assert property (data_port_mode && host_read_cycle |=>
		pin_out[47:40] == $past(host_wdata[7:0]))
		else $error("data port low byte wrong");
endmodule
bind io_port_path io_port_path_properties #(.num_ports(num_ports)) chk (
	.clk_sys(clk_sys), .rst(rst), .req(req), .rdata(rdata), .pin_in(pin_in),
	.pin_out(pin_out), .pin_oe(pin_oe), .pin_fast_slew(pin_fast_slew),
	.host_wdata(host_wdata), .host_read_cycle(host_read_cycle),
	.data_port_mode(data_port_mode), .port_d_special(port_d_special),
	.test_port_pins(test_port_pins), .battery_indicator_en(battery_indicator_en),
	.supply_below_battery(supply_below_battery), .memory_select_off(memory_select_off));
`default_nettype wire

// ### verif/pin_world_model.sv
// pin_world_model: board side of the port pins, resolving each line level
// assumes oe high means the port drives; ext_level is the board's own driver
`timescale 1ns/1ns
`default_nettype none
module pin_world_model (
	input wire logic [55:0] pin_out,
	input wire logic [55:0] pin_oe,
	input wire logic [55:0] ext_level,
	output logic [55:0] pin_in
);
	// ==========
	// a driven line shows the port, a released one the board level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// ### verif/multi_function_io_port_data_path_tb.sv
// multi_function_io_port_data_path_tb: register and pin tests of io_port_path
// assumes the pin world model closes the pin loop; straps driven by the bench
`timescale 1ns/1ns
`default_nettype none
module multi_function_io_port_data_path_tb;
	import port_pkg::*;
	logic clk_sys, rst, rd_cyc, bus_cyc, rst_act, dp_mode, rp_mode, d3_be, bat_en, below;
	logic cs_off, wrh_n, dbe, strobe, lclk;
	reg_req_t req;
	logic [7:0] rdata, test_pins, arr_in, v;
	logic [55:0] pin_in, pin_out, pin_oe, slew, ext;
	logic [15:0] arr_out, arr_oe, haddr, hwdata, hrdata, pattern, hi_addr;
	logic [3:0] d_special;
	int n_errors, cmp_count;
	io_port_path dut (.clk_sys(clk_sys), .rst(rst), .req(req), .rdata(rdata),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_fast_slew(slew),
		.array_out(arr_out), .array_oe(arr_oe), .host_addr(haddr), .host_wdata(hwdata),
		.host_rdata(hrdata), .host_read_cycle(rd_cyc), .host_bus_cycle(bus_cyc),
		.host_reset_active(rst_act), .data_port_mode(dp_mode),
		.reset_pattern_mode(rp_mode), .reset_pattern(pattern), .port_d_special(d_special),
		.port_d_three_is_byte_enable(d3_be), .test_port_pins(test_pins),
		.battery_indicator_en(bat_en), .supply_below_battery(below),
		.array_input_level(arr_in), .high_addr_latched(hi_addr), .address_strobe(strobe),
		.logic_clock_input(lclk), .memory_select_off(cs_off),
		.high_byte_write_enable_n(wrh_n), .data_byte_enable_input(dbe));
	pin_world_model world (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
		.pin_in(pin_in));
	// ==========
	// clock and bus tasks; strobes last exactly one edge
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic wr(input logic [2:0] p, input logic [2:0] s, input logic [7:0] d);
		@(posedge clk_sys) req <= '{rd: 1'b0, wr: 1'b1, port: p, sel: s, wdata: d};
		@(posedge clk_sys) req <= '0;
	endtask
	task automatic rd(input logic [2:0] p, input logic [2:0] s, output logic [7:0] d);
		@(posedge clk_sys) req <= '{rd: 1'b1, wr: 1'b0, port: p, sel: s, wdata: 8'h00};
		@(posedge clk_sys) req <= '0;
		#1 d = rdata;
	endtask
	task automatic settle;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========
	// watchdog: the sequence needs under 150 cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_errors++;
		end_sim();
	end
	// ==========
	// main sequence
	initial begin
		{rst, rd_cyc, bus_cyc, rst_act, dp_mode, rp_mode, d3_be, bat_en, below} = 9'h100;
		{req, test_pins, ext, arr_out, arr_oe, haddr, hwdata, pattern, d_special} = '0;
		n_errors = 0;
		cmp_count = 0;
		ext[23:16] = 8'h3c;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		for (int p = 0; p < 7; p++) begin
			for (int s = 1; s < 5; s++) begin
				rd(p[2:0], s[2:0], v);
				chk("reset value", 16'(v), 16'h0000);
			end
		end
		wr(port_c, reg_output_latch, 8'ha5);
		rd(port_c, reg_output_latch, v);
		chk("port c latch", 16'(v), 16'h00a5);
		wr(port_c, reg_direction, 8'h0f);
		settle();
		chk("port c enable", 16'(pin_oe[23:16]), 16'h000f);
		chk("port c drive", 16'(pin_out[23:16] & 8'h0f), 16'h0005);
		rd(port_c, reg_pin_input_level, v);
		chk("port c level", 16'(v), 16'h0035);
		rd(port_c, reg_output_latch, v);
		chk("port c latch not pins", 16'(v), 16'h00a5);
		wr(port_d, reg_output_latch, 8'hff);
		rd(port_d, reg_output_latch, v);
		chk("port d latch", 16'(v), 16'h000f);
		wr(port_a, reg_control, 8'hff);
		rd(port_a, reg_control, v);
		chk("port a control", 16'(v), 16'h0000);
		@(posedge clk_sys) arr_oe <= 16'h00ff;
		settle();
		chk("array enable", 16'(pin_oe[7:0]), 16'h00ff);
		@(posedge clk_sys) arr_oe <= 16'h0000;
		wr(port_a, reg_drive_select, 8'hff);
		wr(port_a, reg_output_latch, 8'h0f);
		wr(port_a, reg_direction, 8'hff);
		wr(port_c, reg_drive_select, 8'hff);
		settle();
		chk("open drain", 16'(pin_oe[7:0]), 16'h00f0);
		chk("fast slew", 16'(slew[23:16]), 16'h00ff);
		@(posedge clk_sys) d_special <= 4'h4;
		ext[26] <= 1'b1;
		settle();
		chk("deselect", 16'(cs_off), 16'h0001);
		@(posedge clk_sys) ext[26] <= 1'b0;
		settle();
		chk("select", 16'(cs_off), 16'h0000);
		// the latch only opens while port d pin zero carries the address strobe role
		@(posedge clk_sys) haddr <= 16'h1234;
		d_special <= 4'h5;
		ext[24] <= 1'b1;
		settle();
		chk("strobe", 16'(strobe), 16'h0001);
		chk("array inputs", 16'(arr_in), 16'h0001);
		chk("clock input", 16'(lclk), 16'h0000);
		chk("high write enable", 16'(wrh_n), 16'h0001);
		chk("byte enable", 16'(dbe), 16'h0000);
		@(posedge clk_sys) ext[24] <= 1'b0;
		wr(port_e, reg_control, 8'hff);
		wr(port_g, reg_control, 8'hff);
		settle();
		chk("e address", 16'(pin_out[39:32]), 16'h0034);
		chk("g address", 16'(pin_out[55:48]), 16'h0012);
		wr(port_e, reg_control, 8'h00);
		wr(port_g, reg_control, 8'h00);
		@(posedge clk_sys) test_pins <= 8'h0f;
		wr(port_e, reg_direction, 8'hff);
		settle();
		chk("test port", 16'(pin_oe[39:32]), 16'h00f0);
		@(posedge clk_sys) {bat_en, below} <= 2'b11;
		settle();
		chk("battery", 16'(pin_out[39]), 16'h0001);
		@(posedge clk_sys) {dp_mode, rd_cyc} <= 2'b11;
		hwdata <= 16'hc3a5;
		settle();
		chk("data port", pin_out[55:40], 16'hc3a5);
		chk("data enable", pin_oe[55:40], 16'hffff);
		chk("host read data", hrdata, 16'hc3a5);
		@(posedge clk_sys) {rd_cyc, rp_mode, rst_act} <= 3'b011;
		pattern <= 16'h5a96;
		settle();
		chk("reset pattern", pin_out[55:40], 16'h5a96);
		@(posedge clk_sys) rst_act <= 1'b0;
		settle();
		chk("pattern released", pin_oe[55:40], 16'h0000);
		end_sim();
	end
endmodule
`default_nettype wire
